// ### cwd_pkg.sv
// shared constants, types and helpers for the configuration word decoder
package cwd_pkg;
  localparam int CWD_WORD_W = 14;
  localparam int CWD_ADDR_W = 16;
  // program-space locations of the two words
  localparam logic [15:0] CWD_WORD1_ADDR = 16'h2007;
  localparam logic [15:0] CWD_WORD2_ADDR = 16'h2008;
  // erased value of a configuration cell
  localparam logic [13:0] CWD_ERASED = 14'h3FFF;
  // word one field positions
  localparam int CWD_FOSC_LSB = 0;
  localparam int CWD_WDT_BIT = 3;
  localparam int CWD_PWRUP_BIT = 4;
  localparam int CWD_CLR_ROLE_BIT = 5;
  localparam int CWD_PROT_BIT = 6;
  localparam int CWD_BOR_LSB = 8;
  // word one bits 11 and 7 are unimplemented and read as one
  localparam logic [13:0] CWD_W1_ONES = 14'h0880;
  // word two: only bits 5..4 exist, the rest read as one
  localparam int CWD_CAP_LSB = 4;
  localparam logic [13:0] CWD_W2_ONES = 14'h3FCF;
  // clock select codes
  localparam logic [2:0] CWD_FOSC_RC = 3'h7;
  localparam logic [2:0] CWD_FOSC_RC_IO = 3'h6;
  localparam logic [2:0] CWD_FOSC_INT = 3'h5;
  localparam logic [2:0] CWD_FOSC_INTIO = 3'h4;
  localparam logic [2:0] CWD_FOSC_EXT = 3'h3;
  localparam logic [2:0] CWD_FOSC_XHI = 3'h2;
  localparam logic [2:0] CWD_FOSC_XMED = 3'h1;
  localparam logic [2:0] CWD_FOSC_XLOW = 3'h0;
  // regulator capacitor pin codes
  localparam logic [1:0] CWD_CAP_A0 = 2'h0;
  localparam logic [1:0] CWD_CAP_A5 = 2'h1;
  localparam logic [1:0] CWD_CAP_A6 = 2'h2;
  localparam logic [1:0] CWD_CAP_OFF = 2'h3;
  // one-hot capacitor pin outputs: bit 0 port a bit 0, bit 1 bit 5, bit 2 bit 6
  localparam logic [2:0] CWD_CAPPIN_NONE = 3'h0;
  localparam logic [2:0] CWD_CAPPIN_A0 = 3'h1;
  localparam logic [2:0] CWD_CAPPIN_A5 = 3'h2;
  localparam logic [2:0] CWD_CAPPIN_A6 = 3'h4;
  localparam logic [13:0] CWD_RDATA_RST = 14'h0000;

  typedef enum logic [1:0] {CWD_SRC_XTAL, CWD_SRC_EXT, CWD_SRC_INT, CWD_SRC_RC} cwd_src_t;
  typedef enum logic [1:0] {CWD_GAIN_OFF, CWD_GAIN_LOW, CWD_GAIN_MED, CWD_GAIN_HIGH} cwd_gain_t;
  typedef enum logic {CWD_LD_BOOT, CWD_LD_RUN} cwd_ld_t;

  // value of word one as stored and read back
  function automatic logic [13:0] cwd_word1_view(input logic [13:0] w);
    return w | CWD_W1_ONES;
  endfunction : cwd_word1_view

  // value of word two as stored and read back
  function automatic logic [13:0] cwd_word2_view(input logic [1:0] cap);
    return CWD_W2_ONES | ({12'h000, cap} << CWD_CAP_LSB);
  endfunction : cwd_word2_view
endpackage : cwd_pkg

// ### cwd_word_store.sv
// two-word configuration store with a registered read port
`timescale 1ns/100ps
module cwd_word_store
  import cwd_pkg::*;
#(
  parameter int WORD_W = CWD_WORD_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_ok,
  input wire logic rd_sel,
  output logic [WORD_W-1:0] rd_data_q,
  output logic [WORD_W-1:0] word1,
  output logic [WORD_W-1:0] word2
);
  logic [WORD_W-1:0] mem_q [2];

  // cells come up erased; a real part keeps them across power, this model cannot
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_q[0] <= '1;
      mem_q[1] <= '1;
    end else if (clk_en && wr_en) begin
      mem_q[wr_sel] <= wr_data;
    end
  end

  // refused reads return zero so nothing leaks outside programming mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= '0;
    end else if (clk_en && rd_en) begin
      rd_data_q <= rd_ok ? mem_q[rd_sel] : '0;
    end
  end

  assign word1 = mem_q[0];
  assign word2 = mem_q[1];
endmodule : cwd_word_store

// ### cwd_osc_decode.sv
// clock select code to oscillator source and pin roles
`timescale 1ns/100ps
module cwd_osc_decode
  import cwd_pkg::*;
(
  input wire logic [2:0] code,
  output cwd_src_t src,
  output cwd_gain_t gain,
  output logic pin1_io,
  output logic pin2_io,
  output logic pin2_clk_out
);
  // every code is legal, so no default arm is needed
  always_comb begin
    src = CWD_SRC_XTAL;
    gain = CWD_GAIN_OFF;
    pin1_io = 1'b0;
    pin2_io = 1'b0;
    pin2_clk_out = 1'b0;
    unique case (code)
      CWD_FOSC_RC: begin
        src = CWD_SRC_RC;
        pin2_clk_out = 1'b1;
      end
      CWD_FOSC_RC_IO: begin
        src = CWD_SRC_RC;
        pin2_io = 1'b1;
      end
      CWD_FOSC_INT: begin
        src = CWD_SRC_INT;
        pin1_io = 1'b1;
        pin2_clk_out = 1'b1;
      end
      CWD_FOSC_INTIO: begin
        src = CWD_SRC_INT;
        pin1_io = 1'b1;
        pin2_io = 1'b1;
      end
      CWD_FOSC_EXT: begin
        src = CWD_SRC_EXT;
        pin2_io = 1'b1;
      end
      CWD_FOSC_XHI: begin
        gain = CWD_GAIN_HIGH;
      end
      CWD_FOSC_XMED: begin
        gain = CWD_GAIN_MED;
      end
      CWD_FOSC_XLOW: begin
        gain = CWD_GAIN_LOW;
      end
    endcase
  end
endmodule : cwd_osc_decode

// ### cwd_config_decoder.sv
// configuration word store, programming port and static settings decoder
`timescale 1ns/100ps
module cwd_config_decoder
  import cwd_pkg::*;
#(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic prog_mode,
  input wire logic [CWD_ADDR_W-1:0] bus_addr,
  input wire logic [CWD_WORD_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [CWD_WORD_W-1:0] bus_rdata_q,
  input wire logic master_clear_pin_n,
  output cwd_src_t clk_src_q,
  output cwd_gain_t xtal_gain_q,
  output logic pin1_is_io_q,
  output logic pin2_is_io_q,
  output logic pin2_clk_out_q,
  output logic osc_stop_q,
  output logic powerup_delay_en_q,
  output logic watchdog_en_q,
  output logic [1:0] brownout_mode_q,
  output logic master_clear_pin_role_q,
  output logic master_clear_reset_q,
  output logic master_clear_din_q,
  output logic [2:0] regulator_cap_pin_q,
  output logic readout_block_q,
  output logic erase_req_q,
  output logic settings_valid_q
);
  cwd_ld_t ld_q;
  logic prog_q;
  logic load;
  logic hit1;
  logic hit2;
  logic wr_ok;
  logic [CWD_WORD_W-1:0] wr_val;
  logic [CWD_WORD_W-1:0] word1;
  logic [CWD_WORD_W-1:0] word2;
  logic [1:0] cap_code;
  cwd_src_t dec_src;
  cwd_gain_t dec_gain;
  logic dec_pin1_io;
  logic dec_pin2_io;
  logic dec_clk_out;
  logic rst_now;

  // address decode of the two configuration locations
  assign hit1 = (bus_addr == CWD_WORD1_ADDR);
  assign hit2 = (bus_addr == CWD_WORD2_ADDR);
  // running code has no path in: the write strobe and the read data are gated by programming mode
  assign wr_ok = bus_wr && prog_mode && (hit1 || hit2);

  // unimplemented bits are forced to one as they are stored
  assign wr_val = hit1 ? cwd_word1_view(bus_wdata)
                       : cwd_word2_view(bus_wdata[CWD_CAP_LSB+1:CWD_CAP_LSB]);

  cwd_word_store #(
    .WORD_W(CWD_WORD_W)
  ) u_store (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .wr_en(wr_ok),
    .wr_sel(hit2),
    .wr_data(wr_val),
    .rd_en(bus_rd),
    .rd_ok(prog_mode && (hit1 || hit2)),
    .rd_sel(hit2),
    .rd_data_q(bus_rdata_q),
    .word1(word1),
    .word2(word2)
  );

  cwd_osc_decode u_osc (
    .code(word1[CWD_FOSC_LSB+2:CWD_FOSC_LSB]),
    .src(dec_src),
    .gain(dec_gain),
    .pin1_io(dec_pin1_io),
    .pin2_io(dec_pin2_io),
    .pin2_clk_out(dec_clk_out)
  );

  // settings are taken once after reset and again when programming ends,
  // so a half-written word never steers the oscillator mid-session
  assign load = clk_en && ((ld_q == CWD_LD_BOOT) || (prog_q && !prog_mode));
  assign cap_code = word2[CWD_CAP_LSB+1:CWD_CAP_LSB];

  // load sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ld_q <= CWD_LD_BOOT;
    end else if (clk_en) begin
      ld_q <= CWD_LD_RUN;
    end
  end

  // programming mode history for the end-of-session reload
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prog_q <= 1'b0;
    end else if (clk_en) begin
      prog_q <= prog_mode;
    end
  end

  // oscillator source and pin roles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_src_q <= CWD_SRC_XTAL;
      xtal_gain_q <= CWD_GAIN_OFF;
      pin1_is_io_q <= 1'b0;
      pin2_is_io_q <= 1'b0;
      pin2_clk_out_q <= 1'b0;
    end else if (load) begin
      clk_src_q <= dec_src;
      xtal_gain_q <= dec_gain;
      pin1_is_io_q <= dec_pin1_io;
      pin2_is_io_q <= dec_pin2_io;
      pin2_clk_out_q <= dec_clk_out;
    end
  end

  // timers and brown-out each follow only their own bits
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      powerup_delay_en_q <= 1'b0;
      watchdog_en_q <= 1'b0;
      brownout_mode_q <= 2'h0;
    end else if (load) begin
      powerup_delay_en_q <= !word1[CWD_PWRUP_BIT];
      watchdog_en_q <= word1[CWD_WDT_BIT];
      brownout_mode_q <= word1[CWD_BOR_LSB+1:CWD_BOR_LSB];
    end
  end

  // master clear pin role is a static setting
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      master_clear_pin_role_q <= 1'b0;
    end else if (load) begin
      master_clear_pin_role_q <= word1[CWD_CLR_ROLE_BIT];
    end
  end

  // reset asserted only when the pin is the reset input; else it is tied off
  assign rst_now = master_clear_pin_role_q && !master_clear_pin_n;

  // master clear reset, digital input and oscillator stop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      master_clear_reset_q <= 1'b0;
      master_clear_din_q <= 1'b0;
      osc_stop_q <= 1'b0;
    end else if (clk_en) begin
      master_clear_reset_q <= rst_now;
      master_clear_din_q <= !master_clear_pin_role_q && master_clear_pin_n;
      osc_stop_q <= rst_now && ((clk_src_q == CWD_SRC_INT)
                                || (clk_src_q == CWD_SRC_RC));
    end
  end

  // regulator capacitor pin placement
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regulator_cap_pin_q <= CWD_CAPPIN_NONE;
    end else if (load) begin
      if (LOW_VOLTAGE_VARIANT) begin
        regulator_cap_pin_q <= CWD_CAPPIN_NONE;
      end else begin
        unique case (cap_code)
          CWD_CAP_A0: regulator_cap_pin_q <= CWD_CAPPIN_A0;
          CWD_CAP_A5: regulator_cap_pin_q <= CWD_CAPPIN_A5;
          CWD_CAP_A6: regulator_cap_pin_q <= CWD_CAPPIN_A6;
          CWD_CAP_OFF: regulator_cap_pin_q <= CWD_CAPPIN_NONE;
        endcase
      end
    end
  end

  // readout block follows the stored bit live, since it guards programming
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readout_block_q <= 1'b1;
    end else if (clk_en) begin
      readout_block_q <= !word1[CWD_PROT_BIT];
    end
  end

  // one-cycle erase request when protection goes from on to off
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      erase_req_q <= 1'b0;
    end else if (clk_en) begin
      erase_req_q <= wr_ok && hit1 && !word1[CWD_PROT_BIT]
                     && bus_wdata[CWD_PROT_BIT];
    end
  end

  // settings are meaningful from the first load on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      settings_valid_q <= 1'b0;
    end else if (load) begin
      settings_valid_q <= 1'b1;
    end
  end

  // checks on the decoded outputs
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // load is high all through reset; without rstn the releasing edge would start a check
  sequence s_load;
    load && rstn;
  endsequence

  sequence s_unprotect;
    clk_en && wr_ok && hit1 && !word1[CWD_PROT_BIT] && bus_wdata[CWD_PROT_BIT];
  endsequence

  property p_rd_word1;
    clk_en && bus_rd && prog_mode && hit1
      |=> bus_rdata_q == cwd_word1_view($past(word1));
  endproperty
  a_rd_word1: assert property (p_rd_word1) else $error("word one readback wrong");

  property p_rd_locked;
    clk_en && bus_rd && !prog_mode |=> bus_rdata_q == CWD_RDATA_RST;
  endproperty
  a_rd_locked: assert property (p_rd_locked) else $error("read outside programming");

  property p_wr_locked;
    clk_en && bus_wr && !prog_mode |=> $stable(word1) && $stable(word2);
  endproperty
  a_wr_locked: assert property (p_wr_locked) else $error("write outside programming");

  property p_rc;
    s_load ##0 (word1[2:0] == CWD_FOSC_RC)
      |=> clk_src_q == CWD_SRC_RC && pin2_clk_out_q && !pin2_is_io_q;
  endproperty
  a_rc: assert property (p_rc) else $error("rc mode decode wrong");

  property p_intio;
    s_load ##0 (word1[2:0] == CWD_FOSC_INTIO)
      |=> clk_src_q == CWD_SRC_INT && pin1_is_io_q && pin2_is_io_q;
  endproperty
  a_intio: assert property (p_intio) else $error("internal io decode wrong");

  property p_ext;
    s_load ##0 (word1[2:0] == CWD_FOSC_EXT)
      |=> clk_src_q == CWD_SRC_EXT && !pin1_is_io_q && pin2_is_io_q;
  endproperty
  a_ext: assert property (p_ext) else $error("external clock decode wrong");

  property p_xhi;
    s_load ##0 (word1[2:0] == CWD_FOSC_XHI)
      |=> clk_src_q == CWD_SRC_XTAL && xtal_gain_q == CWD_GAIN_HIGH;
  endproperty
  a_xhi: assert property (p_xhi) else $error("high gain decode wrong");

  property p_osc_stop;
    clk_en && rst_now && (clk_src_q == CWD_SRC_RC) |=> osc_stop_q;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");

  property p_timers;
    s_load |=> powerup_delay_en_q == !$past(word1[CWD_PWRUP_BIT])
               && watchdog_en_q == $past(word1[CWD_WDT_BIT]);
  endproperty
  a_timers: assert property (p_timers) else $error("timer enables wrong");

  property p_erase;
    s_unprotect |=> erase_req_q ##1 (!erase_req_q || !$past(clk_en) || $past(wr_ok));
  endproperty
  a_erase: assert property (p_erase) else $error("erase request missing");

  property p_w2_ones;
    (word2 & CWD_W2_ONES) == CWD_W2_ONES;
  endproperty
  a_w2_ones: assert property (p_w2_ones) else $error("word two spare bits not one");

  property p_cap;
    s_load ##0 (cap_code == CWD_CAP_A5)
      |=> regulator_cap_pin_q == (LOW_VOLTAGE_VARIANT ? CWD_CAPPIN_NONE : CWD_CAPPIN_A5);
  endproperty
  a_cap: assert property (p_cap) else $error("capacitor pin wrong");

  property p_master_clear_reset_off;
    clk_en && !master_clear_pin_role_q |=> !master_clear_reset_q;
  endproperty
  a_master_clear_reset_off: assert property (p_master_clear_reset_off) else $error("reset not tied off");

  property p_protect;
    clk_en && !word1[CWD_PROT_BIT] |=> readout_block_q;
  endproperty
  a_protect: assert property (p_protect) else $error("readout not blocked");
endmodule : cwd_config_decoder

// ### cwd_prog_model.sv
// programmer-side model driving the configuration access port
`timescale 1ns/100ps
module cwd_prog_model
  import cwd_pkg::*;
(
  input wire logic core_clk,
  output logic prog_mode,
  output logic [CWD_ADDR_W-1:0] bus_addr,
  output logic [CWD_WORD_W-1:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [CWD_WORD_W-1:0] bus_rdata_q
);
  // idle bus at time zero
  initial begin
    prog_mode = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 14'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // words are only touched inside programming mode
  task automatic set_mode(input logic on);
    @(posedge core_clk);
    prog_mode <= on;
  endtask : set_mode

  // one-cycle write; released lines are inverted so stale values never look valid
  task automatic wr_word(input logic [15:0] addr, input logic [13:0] data);
    @(posedge core_clk);
    bus_addr <= addr;
    bus_wdata <= data;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    bus_addr <= ~addr;
    bus_wdata <= ~data;
  endtask : wr_word

  // one-cycle read; data first stands in the following cycle and holds until the next read
  task automatic rd_word(input logic [15:0] addr, output logic [13:0] data);
    @(posedge core_clk);
    bus_addr <= addr;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    bus_addr <= ~addr;
    #1;
    data = bus_rdata_q;
  endtask : rd_word
endmodule : cwd_prog_model

// ### testbench.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module testbench;
  import cwd_pkg::*;
  logic core_clk, rstn, clk_en, master_clear_pin_n, prog_mode, bus_wr, bus_rd;
  logic [15:0] bus_addr;
  logic [13:0] bus_wdata, bus_rdata_q, rd;
  cwd_src_t clk_src_q;
  cwd_gain_t xtal_gain_q;
  logic pin1_is_io_q, pin2_is_io_q, pin2_clk_out_q, osc_stop_q, powerup_delay_en_q;
  logic watchdog_en_q, master_clear_pin_role_q, master_clear_reset_q, master_clear_din_q;
  logic readout_block_q, erase_req_q, settings_valid_q;
  logic [1:0] brownout_mode_q;
  logic [2:0] regulator_cap_pin_q, lv_cap;
  logic [6:0] osc_now;
  int fails, cmp_count;
  // source(2) gain(2) pin-one io, pin-two io, clock out, indexed by select code
  localparam logic [6:0] OSC_EXP [8] = '{7'h08, 7'h10, 7'h18, 7'h22, 7'h46, 7'h45, 7'h62, 7'h61};
  localparam logic [2:0] CAP_EXP [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

  assign osc_now = {clk_src_q, xtal_gain_q, pin1_is_io_q, pin2_is_io_q, pin2_clk_out_q};

  cwd_prog_model prog (.core_clk(core_clk), .prog_mode(prog_mode), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q));

  cwd_config_decoder DUT (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
    .prog_mode(prog_mode), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .master_clear_pin_n(master_clear_pin_n),
    .clk_src_q(clk_src_q), .xtal_gain_q(xtal_gain_q), .pin1_is_io_q(pin1_is_io_q),
    .pin2_is_io_q(pin2_is_io_q), .pin2_clk_out_q(pin2_clk_out_q), .osc_stop_q(osc_stop_q),
    .powerup_delay_en_q(powerup_delay_en_q), .watchdog_en_q(watchdog_en_q),
    .brownout_mode_q(brownout_mode_q), .master_clear_pin_role_q(master_clear_pin_role_q),
    .master_clear_reset_q(master_clear_reset_q), .master_clear_din_q(master_clear_din_q),
    .regulator_cap_pin_q(regulator_cap_pin_q), .readout_block_q(readout_block_q),
    .erase_req_q(erase_req_q), .settings_valid_q(settings_valid_q));

  // low-voltage variant shares every input; only its capacitor pins are watched
  cwd_config_decoder #(.LOW_VOLTAGE_VARIANT(1'b1)) dut_lv (.core_clk(core_clk), .rstn(rstn),
    .clk_en(clk_en), .prog_mode(prog_mode), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(), .master_clear_pin_n(master_clear_pin_n),
    .clk_src_q(), .xtal_gain_q(), .pin1_is_io_q(), .pin2_is_io_q(), .pin2_clk_out_q(),
    .osc_stop_q(), .powerup_delay_en_q(), .watchdog_en_q(), .brownout_mode_q(),
    .master_clear_pin_role_q(), .master_clear_reset_q(), .master_clear_din_q(),
    .regulator_cap_pin_q(lv_cap), .readout_block_q(), .erase_req_q(), .settings_valid_q());

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // settings reload at the edge that first sees programming mode off
  task automatic reload;
    prog.set_mode(1'b0);
    @(posedge core_clk);
    #1;
  endtask : reload

  task automatic program_word(input logic [15:0] addr, input logic [13:0] w);
    prog.set_mode(1'b1);
    prog.wr_word(addr, w);
    reload();
  endtask : program_word

  // pin level applied for two edges; expect {reset, oscillator stop, digital input}
  task automatic master_clear_reset_case(input logic [13:0] w, input logic pin, input logic [2:0] exp);
    program_word(16'h2007, w);
    @(posedge core_clk);
    master_clear_pin_n <= pin;
    repeat (2) @(posedge core_clk);
    #1;
    check({13'h0000, master_clear_reset_q, osc_stop_q, master_clear_din_q}, {13'h0000, exp});
    @(posedge core_clk);
    master_clear_pin_n <= 1'b1;
  endtask : master_clear_reset_case

  // hang guard, far beyond the fewer than two hundred cycles the sequence needs
  initial begin
    #50000;
    fails++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    master_clear_pin_n = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    // erased words: rc with clock out, timer off, watchdog on, pin is reset
    check({9'h000, osc_now}, 16'h0061);
    check({12'h000, powerup_delay_en_q, watchdog_en_q, master_clear_pin_role_q,
      readout_block_q}, 16'h0006);
    check({11'h000, brownout_mode_q, regulator_cap_pin_q}, 16'h0018);
    check({15'h0000, settings_valid_q}, 16'h0001);
    // store access inside programming mode
    prog.set_mode(1'b1);
    prog.rd_word(16'h2007, rd);
    check({2'h0, rd}, 16'h3FFF);
    prog.wr_word(16'h2007, 14'h0000);
    prog.rd_word(16'h2007, rd);
    check({2'h0, rd}, 16'h0880);
    check({15'h0000, readout_block_q}, 16'h0001);
    prog.wr_word(16'h2008, 14'h0000);
    prog.rd_word(16'h2008, rd);
    check({2'h0, rd}, 16'h3FCF);
    prog.rd_word(16'h2009, rd);
    check({2'h0, rd}, 16'h0000);
    // lifting protection raises a one-cycle erase request
    prog.wr_word(16'h2007, 14'h3FFF);
    #1;
    check({15'h0000, erase_req_q}, 16'h0001);
    @(posedge core_clk);
    #1;
    check({15'h0000, erase_req_q}, 16'h0000);
    // outside programming mode reads give zero and writes are dropped
    reload();
    prog.rd_word(16'h2007, rd);
    check({2'h0, rd}, 16'h0000);
    prog.wr_word(16'h2007, 14'h0000);
    prog.set_mode(1'b1);
    prog.rd_word(16'h2007, rd);
    check({2'h0, rd}, 16'h3FFF);
    // clock enable low freezes the store, so a write in programming mode is lost
    @(posedge core_clk);
    clk_en <= 1'b0;
    prog.wr_word(16'h2007, 14'h0000);
    clk_en <= 1'b1;
    prog.rd_word(16'h2007, rd);
    check({2'h0, rd}, 16'h3FFF);
    // every clock select code
    for (int c = 0; c < 8; c++) begin
      program_word(16'h2007, {11'h7FF, 3'(c)});
      check({9'h000, osc_now}, {9'h000, OSC_EXP[c]});
    end
    // every capacitor placement, and the variant without regulator
    for (int k = 0; k < 4; k++) begin
      program_word(16'h2008, {8'hFF, 2'(k), 4'hF});
      check({13'h0000, regulator_cap_pin_q}, {13'h0000, CAP_EXP[k]});
      check({13'h0000, lv_cap}, 16'h0000);
    end
    // brown-out off, timer bit low, watchdog bit low
    program_word(16'h2007, 14'h3CE7);
    check({12'h000, powerup_delay_en_q, watchdog_en_q, brownout_mode_q}, 16'h0008);
    master_clear_reset_case(14'h3FFD, 1'b0, 3'h6);
    master_clear_reset_case(14'h3FFF, 1'b0, 3'h6);
    master_clear_reset_case(14'h3FFA, 1'b0, 3'h4);
    master_clear_reset_case(14'h3FDD, 1'b0, 3'h0);
    master_clear_reset_case(14'h3FDD, 1'b1, 3'h1);
    complete_run();
  end
endmodule : testbench
